// ==== hdl/rdls_pkg.sv ====
// Constants shared by the pixel bridge front end
package rdls_pkg;
  // Clock and timing
  localparam int REF_PERIOD_NS = 100;
  localparam int STATIC_NS     = 2000;
  localparam int STATIC_CYC    =
    (STATIC_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam logic [4:0] STATIC_MAX = 5'(STATIC_CYC);
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ERRCNT = 8'h08;
  localparam int ADDR_HI = 7;
  // Control register fields
  localparam int CTRL_W       = 3;
  localparam int CB_LUT_EN    = 0;
  localparam int CB_LANE3     = 1;
  localparam int CB_AUTO_PD   = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h2;
  // Status register fields
  localparam int SB_ASLEEP    = 0;
  localparam int SB_PCLK_RUN  = 1;
  localparam int SB_FULL      = 2;
  localparam int SB_EMPTY     = 3;
  localparam int SB_TEST      = 4;
  localparam int SB_TIE       = 5;
  localparam int SB_SEQ_LO    = 8;
  // Configuration frame: rw, table select, index, data
  localparam int SPI_BITS   = 24;
  localparam logic [4:0] SPI_HDR_END = 5'h10;
  localparam logic [4:0] SPI_LAST    = 5'h17;
  localparam logic [4:0] SPI_DONE    = 5'h18;
  localparam int SPI_RW     = 23;
  localparam int SPI_SEL_HI = 22;
  localparam int SPI_SEL_LO = 21;
  localparam int SPI_IDX_HI = 15;
  localparam int SPI_IDX_LO = 8;
  localparam int HDR_SHIFT  = 8;
  localparam logic [1:0] SEL_CTRL = 2'h3;
  // Colour tables
  localparam int TBL_N     = 3;
  localparam int TBL_DEPTH = 256;
  // Link word: parity, seq[1:0], de, hs, vs, rgb 6:6:6
  localparam int WORD_W  = 24;
  localparam int FIFO_D  = 32;
  localparam logic [3:0] STEPS3 = 4'h8;
  localparam logic [3:0] STEPS2 = 4'hC;
  localparam int SYNC_W  = 33;
endpackage : rdls_pkg

// ==== hdl/rdls_top.sv ====
// Pixel bridge: capture, colour table, dither, FIFO and lane serializer
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.

`timescale 1ns/10ps

// Two-flop synchroniser for a group of pins
module rdls_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= '0;
      q    <= '0;
    end
    else
    begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule : rdls_sync

// Flip-flop FIFO with valid/ready on both sides
module rdls_fifo #(
  parameter int W = 24,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         flush,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  // Pointers and fill count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else if (flush)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rdls_fifo

module rdls_top (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // AHB-Lite register slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Parallel video input
  input  wire logic        PIXEL_CLK,
  input  wire logic [7:0]  RED,
  input  wire logic [7:0]  GREEN,
  input  wire logic [7:0]  BLUE,
  input  wire logic        VERTICAL_SYNC,
  input  wire logic        PIXEL_VALID_WINDOW,
  // Configuration port and shared pin
  input  wire logic        CONFIG_SELECT_N,
  input  wire logic        CONFIG_SCL,
  input  wire logic        CONFIG_DATA_OR_HSYNC_I,
  output logic             CONFIG_DATA_OR_HSYNC_O,
  output logic             CONFIG_DATA_OR_HSYNC_OE_N,
  // Straps
  input  wire logic        POWER_DOWN_N,
  input  wire logic        TEST_MODE_SELECT,
  input  wire logic        RESERVED_TIE_HIGH,
  // Serial link
  output logic      [2:0]  SERIAL_DATA_LANES,
  output logic             SERIAL_CLOCK_LANE
);
  typedef enum logic {SR_IDLE, SR_SHIFT} rdls_ser_t;

  logic [rdls_pkg::SYNC_W-1:0] pin_s;
  logic [7:0] red_s, green_s, blue_s;
  logic pclk_s, vs_s, de_s, sel_n_s, scl_s, sdi_s, pd_n_s, tm_s, tie_s;
  logic pclk_d_r, scl_d_r;
  logic pclk_rise, scl_rise, scl_fall;
  logic [4:0] idle_cnt_r;
  logic pclk_static, link_off;
  logic [rdls_pkg::CTRL_W-1:0] ctrl_r;
  logic [15:0] errcnt_r;
  // Bus data phase
  logic wr_pend_r;
  logic [rdls_pkg::ADDR_HI:0] wr_addr_r;
  logic addr_ok;
  logic [31:0] rd_val;
  // Config port
  logic spi_on;
  logic [4:0] spi_cnt_r;
  logic [rdls_pkg::SPI_BITS-1:0] spi_sh_r;
  logic [rdls_pkg::SPI_BITS-1:0] spi_word;
  logic spi_wr;
  logic [7:0] rd_byte_r;
  logic [7:0] hdr_byte;
  // Colour tables
  logic [7:0] lut_r [rdls_pkg::TBL_N][rdls_pkg::TBL_DEPTH];
  // Video path
  logic vs_d_r, hs_d_r, de_d_r;
  logic hs_now;
  logic [7:0] r_m, g_m, b_m;
  logic x0_r, y0_r, frm_r;
  logic [1:0] bias;
  logic [5:0] r_d, g_d, b_d;
  logic [1:0] seq_r;
  logic [rdls_pkg::WORD_W-1:0] word;
  logic cap, err_data, err_clk;
  logic f_ready, f_valid, f_pop;
  logic [rdls_pkg::WORD_W-1:0] f_data;
  // Serializer
  rdls_ser_t ser_r;
  logic [rdls_pkg::WORD_W-1:0] ser_sh_r;
  logic [3:0] step_r;
  logic [3:0] steps;

  // Every pin from outside the clock domain passes two flops
  rdls_sync #(.W(rdls_pkg::SYNC_W)) u_sync (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .d   ({PIXEL_CLK, RED, GREEN, BLUE, VERTICAL_SYNC,
           PIXEL_VALID_WINDOW, CONFIG_SELECT_N, CONFIG_SCL,
           CONFIG_DATA_OR_HSYNC_I, POWER_DOWN_N, TEST_MODE_SELECT,
           RESERVED_TIE_HIGH}),
    .q   (pin_s)
  );
  assign {pclk_s, red_s, green_s, blue_s, vs_s, de_s, sel_n_s, scl_s,
          sdi_s, pd_n_s, tm_s, tie_s} = pin_s;

  // Edge detection on synchronised clocks
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pclk_d_r <= 1'b0;
      scl_d_r  <= 1'b0;
    end
    else
    begin
      pclk_d_r <= pclk_s;
      scl_d_r  <= scl_s;
    end
  end
  assign pclk_rise = pclk_s & ~pclk_d_r;
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;

  // Pixel clock watchdog: static after no edge for the timeout
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      idle_cnt_r <= rdls_pkg::STATIC_MAX;
    else if (pclk_s != pclk_d_r)
      idle_cnt_r <= '0;
    else if (idle_cnt_r != rdls_pkg::STATIC_MAX)
      idle_cnt_r <= idle_cnt_r + 5'h01;
  end
  // An edge in this cycle ends the static state at once, so a clock
  // restart wakes the link in time to take its first pixel
  assign pclk_static = (idle_cnt_r == rdls_pkg::STATIC_MAX)
                       & (pclk_s == pclk_d_r);
  // Sleep or auto power-down stops the link
  assign link_off = ~pd_n_s
    | (ctrl_r[rdls_pkg::CB_AUTO_PD] & pclk_static);

  // Bus: decode and read data driven in the data phase
  assign addr_ok = (HADDR[31:rdls_pkg::ADDR_HI+1] == '0);
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (addr_ok)
    begin
      unique case (HADDR[rdls_pkg::ADDR_HI:0])
        rdls_pkg::OFS_CTRL:
          rd_val[rdls_pkg::CTRL_W-1:0] = ctrl_r;
        rdls_pkg::OFS_STATUS:
        begin
          rd_val[rdls_pkg::SB_ASLEEP]   = link_off;
          rd_val[rdls_pkg::SB_PCLK_RUN] = ~pclk_static;
          rd_val[rdls_pkg::SB_FULL]     = ~f_ready;
          rd_val[rdls_pkg::SB_EMPTY]    = ~f_valid;
          rd_val[rdls_pkg::SB_TEST]     = tm_s;
          rd_val[rdls_pkg::SB_TIE]      = tie_s;
          rd_val[rdls_pkg::SB_SEQ_LO+:2] = seq_r;
        end
        rdls_pkg::OFS_ERRCNT:
          rd_val[15:0] = errcnt_r;
        default:
          rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Bus: one-cycle OKAY answers, writes land at the data phase end
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else if (HREADY)
    begin
      wr_pend_r <= HSEL & HTRANS[1] & HWRITE & addr_ok;
      wr_addr_r <= HADDR[rdls_pkg::ADDR_HI:0];
      if (HSEL & HTRANS[1] & ~HWRITE)
        HRDATA <= rd_val;
    end
  end

  // Control register: bus or config port, defaults while asleep
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ctrl_r <= rdls_pkg::CTRL_RST;
    else if (~pd_n_s)
      ctrl_r <= rdls_pkg::CTRL_RST;
    else if (wr_pend_r && wr_addr_r == rdls_pkg::OFS_CTRL)
      ctrl_r <= HWDATA[rdls_pkg::CTRL_W-1:0];
    else if (spi_wr && spi_word[rdls_pkg::SPI_SEL_HI:rdls_pkg::SPI_SEL_LO]
             == rdls_pkg::SEL_CTRL)
      ctrl_r <= spi_word[rdls_pkg::CTRL_W-1:0];
  end

  // Config port gating and frame assembly
  assign spi_on   = ~sel_n_s & pd_n_s & pclk_static;
  assign spi_word = {spi_sh_r[rdls_pkg::SPI_BITS-2:0], sdi_s};
  assign spi_wr   = spi_on & scl_rise & (spi_cnt_r == rdls_pkg::SPI_LAST)
                    & ~spi_word[rdls_pkg::SPI_RW];
  // Header lookup for reads: table entry or control register
  always_comb
  begin
    hdr_byte = 8'h00;
    if (spi_sh_r[rdls_pkg::SPI_SEL_HI-rdls_pkg::HDR_SHIFT
                 -:2] == rdls_pkg::SEL_CTRL)
      hdr_byte[rdls_pkg::CTRL_W-1:0] = ctrl_r;
    else
      hdr_byte = lut_r[spi_sh_r[rdls_pkg::SPI_SEL_HI-rdls_pkg::HDR_SHIFT
                       -:2]][spi_sh_r[7:0]];
  end

  // Config shift register; pin driven only in a read's data byte
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      spi_cnt_r                 <= '0;
      spi_sh_r                  <= '0;
      rd_byte_r                 <= 8'h00;
      CONFIG_DATA_OR_HSYNC_O    <= 1'b0;
      CONFIG_DATA_OR_HSYNC_OE_N <= 1'b1;
    end
    else if (~spi_on)
    begin
      spi_cnt_r                 <= '0;
      CONFIG_DATA_OR_HSYNC_OE_N <= 1'b1;
    end
    else
    begin
      if (scl_rise && spi_cnt_r != rdls_pkg::SPI_DONE)
      begin
        spi_sh_r  <= spi_word;
        spi_cnt_r <= spi_cnt_r + 5'h01;
      end
      if (scl_fall && spi_sh_r[rdls_pkg::SPI_RW-rdls_pkg::HDR_SHIFT]
          && spi_cnt_r == rdls_pkg::SPI_HDR_END)
      begin
        CONFIG_DATA_OR_HSYNC_OE_N <= 1'b0;
        CONFIG_DATA_OR_HSYNC_O    <= hdr_byte[7];
        rd_byte_r                 <= {hdr_byte[6:0], 1'b0};
      end
      else if (scl_fall && spi_cnt_r > rdls_pkg::SPI_HDR_END
               && spi_cnt_r < rdls_pkg::SPI_DONE)
      begin
        CONFIG_DATA_OR_HSYNC_O <= rd_byte_r[7];
        rd_byte_r              <= {rd_byte_r[6:0], 1'b0};
      end
      else if (scl_fall && spi_cnt_r == rdls_pkg::SPI_DONE)
        CONFIG_DATA_OR_HSYNC_OE_N <= 1'b1;
    end
  end

  // Colour tables: written by config port, kept through sleep
  always_ff @(posedge REF_CLK)
  begin
    if (spi_wr && spi_word[rdls_pkg::SPI_SEL_HI:rdls_pkg::SPI_SEL_LO]
        != rdls_pkg::SEL_CTRL)
      lut_r[spi_word[rdls_pkg::SPI_SEL_HI:rdls_pkg::SPI_SEL_LO]]
           [spi_word[rdls_pkg::SPI_IDX_HI:rdls_pkg::SPI_IDX_LO]]
        <= spi_word[7:0];
  end

  // Shared pin is horizontal sync when not selected
  assign hs_now = sel_n_s & sdi_s;

  // Optional remap; bit 7 is the table index MSB
  assign r_m = ctrl_r[rdls_pkg::CB_LUT_EN] ? lut_r[0][red_s]   : red_s;
  assign g_m = ctrl_r[rdls_pkg::CB_LUT_EN] ? lut_r[1][green_s] : green_s;
  assign b_m = ctrl_r[rdls_pkg::CB_LUT_EN] ? lut_r[2][blue_s]  : blue_s;

  // Ordered 2x2 dither, pattern flips each frame
  assign bias = {x0_r ^ y0_r ^ frm_r, y0_r};
  function automatic logic [5:0] rdls_dith(input logic [7:0] c,
                                           input logic [1:0] b);
    logic [8:0] s;
    s = {1'b0, c} + {7'h00, b};
    rdls_dith = s[8] ? 6'h3F : s[7:2];
  endfunction : rdls_dith
  // Pixels outside the window carry zero colour
  assign r_d = de_s ? rdls_dith(r_m, bias) : 6'h00;
  assign g_d = de_s ? rdls_dith(g_m, bias) : 6'h00;
  assign b_d = de_s ? rdls_dith(b_m, bias) : 6'h00;
  assign word = {^{seq_r, de_s, hs_now, vs_s, r_d, g_d, b_d},
                 seq_r, de_s, hs_now, vs_s, r_d, g_d, b_d};

  assign cap      = pclk_rise & ~link_off;
  assign err_data = cap & ~f_ready;
  assign err_clk  = pclk_static & de_d_r;

  // Pixel position, frame parity, sync history
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      vs_d_r <= 1'b0;
      hs_d_r <= 1'b0;
      de_d_r <= 1'b0;
      x0_r   <= 1'b0;
      y0_r   <= 1'b0;
      frm_r  <= 1'b0;
    end
    else if (pclk_rise)
    begin
      vs_d_r <= vs_s;
      hs_d_r <= hs_now;
      de_d_r <= de_s;
      x0_r   <= de_s ? ~x0_r : 1'b0;
      if (vs_s & ~vs_d_r)
      begin
        frm_r <= ~frm_r;
        y0_r  <= 1'b0;
      end
      else if (de_d_r & ~de_s)
        y0_r <= ~y0_r;
    end
    else if (pclk_static)
      de_d_r <= 1'b0;
  end

  // Frame sequence: counts frames, restarts after an error
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      seq_r <= 2'h0;
    else if (err_data | err_clk)
      seq_r <= 2'h0;
    else if (pclk_rise & vs_s & ~vs_d_r)
      seq_r <= seq_r + 2'h1;
  end

  // Error count, cleared while asleep
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      errcnt_r <= 16'h0000;
    else if (~pd_n_s)
      errcnt_r <= 16'h0000;
    else if ((err_data | err_clk) && errcnt_r != 16'hFFFF)
      errcnt_r <= errcnt_r + 16'h0001;
  end

  rdls_fifo #(.W(rdls_pkg::WORD_W), .D(rdls_pkg::FIFO_D)) u_fifo (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .flush     (~pd_n_s),
    .in_valid  (cap),
    .in_data   (word),
    .in_ready  (f_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_pop)
  );

  // Serializer: lane count picks steps per word
  assign steps = ctrl_r[rdls_pkg::CB_LANE3] ? rdls_pkg::STEPS3
                                            : rdls_pkg::STEPS2;
  assign f_pop = (ser_r == SR_IDLE) & ~link_off & f_valid;

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ser_r             <= SR_IDLE;
      ser_sh_r          <= '0;
      step_r            <= 4'h0;
      SERIAL_DATA_LANES <= 3'h0;
      SERIAL_CLOCK_LANE <= 1'b0;
    end
    else if (link_off)
    begin
      ser_r             <= SR_IDLE;
      SERIAL_DATA_LANES <= 3'h0;
      SERIAL_CLOCK_LANE <= 1'b0;
    end
    else
    begin
      unique case (ser_r)
        SR_IDLE:
        begin
          SERIAL_CLOCK_LANE <= 1'b0;
          SERIAL_DATA_LANES <= 3'h0;
          if (f_valid)
          begin
            ser_sh_r <= f_data;
            step_r   <= 4'h0;
            ser_r    <= SR_SHIFT;
          end
        end
        SR_SHIFT:
        begin
          SERIAL_CLOCK_LANE <= ~SERIAL_CLOCK_LANE;
          if (ctrl_r[rdls_pkg::CB_LANE3])
          begin
            SERIAL_DATA_LANES <= ser_sh_r[23:21];
            ser_sh_r          <= {ser_sh_r[20:0], 3'h0};
          end
          else
          begin
            SERIAL_DATA_LANES <= {1'b0, ser_sh_r[23:22]};
            ser_sh_r          <= {ser_sh_r[21:0], 2'h0};
          end
          step_r <= step_r + 4'h1;
          if (step_r == steps - 4'h1)
            ser_r <= SR_IDLE;
        end
      endcase
    end
  end
endmodule : rdls_top

// ==== sim/rdls_checker.sv ====
// Port-level assertions for the pixel bridge
`timescale 1ns/10ps
module rdls_checker (
  // Clock, reset and register bus
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  // Video, config and link pins
  input wire logic        PIXEL_CLK,
  input wire logic        CONFIG_SELECT_N,
  input wire logic        POWER_DOWN_N,
  input wire logic        CONFIG_DATA_OR_HSYNC_OE_N,
  input wire logic [2:0]  SERIAL_DATA_LANES,
  input wire logic        SERIAL_CLOCK_LANE
);
  logic       wr_pend_r;
  logic [2:0] ctrl_r;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  // Remember a control write address phase
  always_ff @(posedge REF_CLK or posedge SYS_RST)
    if (SYS_RST)
      wr_pend_r <= 1'h0;
    else if (HREADY)
      wr_pend_r <= HSEL && HTRANS[1] && HWRITE && HADDR == 32'h0;

  // Mirror of the control word as written over the bus (config port writes not followed), default again while asleep
  always_ff @(posedge REF_CLK or posedge SYS_RST)
    if (SYS_RST)
      ctrl_r <= rdls_pkg::CTRL_RST;
    else if (!POWER_DOWN_N)
      ctrl_r <= rdls_pkg::CTRL_RST;
    else if (wr_pend_r && HREADY)
      ctrl_r <= HWDATA[2:0];

  sequence s_asleep;
    !POWER_DOWN_N [*8];
  endsequence

  sequence s_awake_edge;
    POWER_DOWN_N [*6] ##0 $rose(PIXEL_CLK);
  endsequence

  a_pclk_frees_pin : assert property (
    $rose(PIXEL_CLK) |-> ##[0:5] CONFIG_DATA_OR_HSYNC_OE_N)
    else $error("shared pin driven while pixel clock runs");
  a_drive_when_sel : assert property (
    $fell(CONFIG_DATA_OR_HSYNC_OE_N) |-> !$past(CONFIG_SELECT_N, 3))
    else $error("shared pin driven without select");
  a_hsync_not_drv : assert property (
    CONFIG_SELECT_N [*6] |-> CONFIG_DATA_OR_HSYNC_OE_N)
    else $error("shared pin driven while it is hsync");
  a_sleep_pin_off : assert property (
    s_asleep |-> CONFIG_DATA_OR_HSYNC_OE_N)
    else $error("config port active while asleep");
  a_sleep_link_idle : assert property (
    s_asleep |-> SERIAL_DATA_LANES == 3'h0 && !SERIAL_CLOCK_LANE)
    else $error("link active while asleep");
  a_awake_sends : assert property (
    s_awake_edge |-> ##[2:60] SERIAL_CLOCK_LANE)
    else $error("no link activity after a pixel");
  a_clk_lane_pulse : assert property (
    SERIAL_CLOCK_LANE |=> !SERIAL_CLOCK_LANE)
    else $error("clock lane high for two cycles");
  a_two_lane_quiet : assert property (
    !ctrl_r[1] |-> SERIAL_DATA_LANES[2] == 1'h0)
    else $error("third lane active in two lane mode");
endmodule : rdls_checker

bind rdls_top rdls_checker rdls_checker_inst (
  .REF_CLK                   (REF_CLK),
  .SYS_RST                   (SYS_RST),
  .HSEL                      (HSEL),
  .HADDR                     (HADDR),
  .HTRANS                    (HTRANS),
  .HWRITE                    (HWRITE),
  .HWDATA                    (HWDATA),
  .HREADY                    (HREADY),
  .PIXEL_CLK                 (PIXEL_CLK),
  .CONFIG_SELECT_N           (CONFIG_SELECT_N),
  .POWER_DOWN_N              (POWER_DOWN_N),
  .CONFIG_DATA_OR_HSYNC_OE_N (CONFIG_DATA_OR_HSYNC_OE_N),
  .SERIAL_DATA_LANES         (SERIAL_DATA_LANES),
  .SERIAL_CLOCK_LANE         (SERIAL_CLOCK_LANE)
);

// ==== sim/rdls_host_model.sv ====
// Behavioural host that drives the parallel video bus
`timescale 1ns/10ps
module rdls_host_model (
  // Pixel values from the bench
  input wire logic       run,
  input wire logic [7:0] r_in,
  input wire logic [7:0] g_in,
  input wire logic [7:0] b_in,
  input wire logic       vs_in,
  input wire logic       hs_in,
  input wire logic       de_in,
  output logic           took,
  // Video bus toward the bridge
  output logic           pclk,
  output logic [7:0]     r_o,
  output logic [7:0]     g_o,
  output logic [7:0]     b_o,
  output logic           vs_o,
  output logic           hs_o,
  output logic           de_o
);
  // Clock runs only inside a frame; data moves in the low phase
  initial
  begin
    {pclk, took, r_o, g_o, b_o, vs_o, hs_o, de_o} = '0;
    forever
    begin
      @(posedge run);
      #37;
      while (run)
      begin
        {r_o, g_o, b_o, de_o} = {r_in, g_in, b_in, de_in};
        hs_o = hs_in;
        vs_o = vs_in;
        took = ~took;
        #400 pclk = 1'h1;
        #400 pclk = 1'h0;
      end
    end
  end
endmodule : rdls_host_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the pixel bridge
`timescale 1ns/10ps
module tb_top;
  logic        ref_clk = '0, sys_rst = '1, hsel = '0, hwrite = '0;
  logic [1:0]  htrans = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic        hreadyout, hresp, sdo, oe_n, clk_lane, pin, cl_prev = '0;
  logic        sel_n = '1, scl = '0, sda = '0, pd_n = '1;
  logic        run = '0, took, pclk, vs, hs, de;
  logic        vsi = '0, hsi = '0, dei = '0, three = '1, ign = '0, tm = '0;
  logic [7:0]  r, g, b, ri = '0, gi = '0, bi = '0;
  logic [2:0]  lanes;
  logic [23:0] w;
  logic [20:0] q[$], e;
  int          error_cnt = 0, num_checks = 0, seed = 82, steps = 0;

  // Clock and shared pin level
  always #50 ref_clk = ~ref_clk;
  assign pin = !oe_n ? sdo : (sel_n ? hs : sda);

  rdls_top rdls_top_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PIXEL_CLK(pclk), .RED(r),
    .GREEN(g), .BLUE(b), .VERTICAL_SYNC(vs), .PIXEL_VALID_WINDOW(de),
    .CONFIG_SELECT_N(sel_n), .CONFIG_SCL(scl),
    .CONFIG_DATA_OR_HSYNC_I(pin), .CONFIG_DATA_OR_HSYNC_O(sdo),
    .CONFIG_DATA_OR_HSYNC_OE_N(oe_n), .POWER_DOWN_N(pd_n),
    .TEST_MODE_SELECT(tm), .RESERVED_TIE_HIGH(1'h1),
    .SERIAL_DATA_LANES(lanes), .SERIAL_CLOCK_LANE(clk_lane));

  rdls_host_model rdls_host_model_inst (.run(run), .r_in(ri), .g_in(gi),
    .b_in(bi), .vs_in(vsi), .hs_in(hsi), .de_in(dei), .took(took),
    .pclk(pclk), .r_o(r), .g_o(g), .b_o(b), .vs_o(vs), .hs_o(hs),
    .de_o(de));

  task automatic chk(input logic [31:0] got, exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // One single-word bus transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : ahb

  task automatic rdr(input logic [7:0] a);
    ahb(1'h0, a, 32'h0);
  endtask : rdr

  // One config frame, MSB first; read bits gathered into rd
  task automatic cfg(input logic [23:0] f);
    @(posedge ref_clk);
    sel_n <= 1'h0;
    for (int i = 23; i >= 0; i--)
    begin
      repeat (6) @(posedge ref_clk);
      scl <= 1'h0;
      sda <= (i < 8 && f[23]) ? ~sda : f[i];
      repeat (6) @(posedge ref_clk);
      rd[i] = pin;
      scl <= 1'h1;
    end
    repeat (6) @(posedge ref_clk);
    scl <= 1'h0;
    repeat (6) @(posedge ref_clk);
    sel_n <= 1'h1;
  endtask : cfg

  // Send n pixels; mode 1 uses table entries, mode 2 floods the buffer
  task automatic frame(input int n, input int mode);
    logic [31:0] x;
    logic [7:0]  er, eg, eb;
    logic        d, v;
    for (int k = 0; k < n; k++)
    begin
      x = $random(seed);
      er = mode == 1 ? 8'h80 : x[7:0] & 8'hFC;
      eg = mode == 1 ? 8'h10 : x[15:8] & 8'hFC;
      eb = mode == 1 ? 8'hFC : x[23:16] & 8'hFC;
      d = x[26] | x[27];
      v = mode != 2 && x[24];
      @(posedge ref_clk);
      ri <= mode == 1 ? 8'h40 : er;
      gi <= mode == 1 ? 8'h40 : eg;
      bi <= mode == 1 ? 8'h40 : eb;
      vsi <= v;
      hsi <= x[25];
      dei <= d;
      run <= 1'h1;
      @(took);
      if (mode != 2)
        q.push_back({d, x[25], v, d ? {er[7:2], eg[7:2], eb[7:2]} : 18'h0});
      if (k == n - 1)
        run <= 1'h0;
    end
  endtask : frame

  // Wait for the buffer and the line to go quiet
  task automatic drain();
    repeat (12) @(posedge ref_clk);
    do rdr(8'h04); while (rd[3] !== 1'h1);
    repeat (25) @(posedge ref_clk);
  endtask : drain

  // Rebuild link words from the lanes and compare with the notes
  always @(negedge ref_clk)
  begin
    if (clk_lane !== cl_prev)
    begin
      w = three ? {w[20:0], lanes} : {w[21:0], lanes[1:0]};
      steps++;
      if (steps == (three ? 8 : 12))
      begin
        steps = 0;
        if (!ign)
        begin
          chk(q.size() != 0, 32'h1, "word count");
          e = q.pop_front();
          chk(w[17:0], e[17:0], "colour");
          chk({^w, w[20:18]}, {1'h0, e[20:18]}, "flags");
        end
      end
    end
    cl_prev = clk_lane;
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rdr(8'h00);
    chk(rd, 32'h2, "ctrl default");
    rdr(8'h04);
    chk(rd & 32'h3E, 32'h28, "status idle");
    rdr(8'h0C);
    chk(rd, 32'h0, "unmapped");
    chk(hresp, 32'h0, "okay");
    frame(20, 0);
    drain();
    cfg({1'h0, 2'h0, 5'h0, 8'h40, 8'h80});
    cfg({1'h0, 2'h1, 5'h0, 8'h40, 8'h10});
    cfg({1'h0, 2'h2, 5'h0, 8'h40, 8'hFC});
    cfg({1'h1, 2'h0, 5'h0, 8'h40, 8'h00});
    chk(rd[7:0], 8'h80, "red entry");
    cfg({1'h0, 2'h3, 5'h0, 8'h00, 8'h03});
    rdr(8'h00);
    chk(rd, 32'h3, "ctrl by port");
    frame(6, 1);
    drain();
    pd_n <= 1'h0;
    tm <= 1'h1;
    repeat (10) @(posedge ref_clk);
    rdr(8'h00);
    chk(rd, 32'h2, "ctrl asleep");
    rdr(8'h04);
    chk(rd[0], 1'h1, "link off");
    chk(rd[4], 1'h1, "test pin");
    cfg({1'h0, 2'h0, 5'h0, 8'h40, 8'h55});
    tm <= 1'h0;
    pd_n <= 1'h1;
    repeat (10) @(posedge ref_clk);
    cfg({1'h1, 2'h1, 5'h0, 8'h40, 8'h00});
    chk(rd[7:0], 8'h10, "green kept");
    cfg({1'h1, 2'h0, 5'h0, 8'h40, 8'h00});
    chk(rd[7:0], 8'h80, "refused asleep");
    ahb(1'h1, 8'h00, 32'h6);
    repeat (30) @(posedge ref_clk);
    rdr(8'h04);
    chk(rd[0], 1'h1, "auto off");
    frame(4, 0);
    drain();
    ahb(1'h1, 8'h00, 32'h0);
    three = 1'h0;
    ign = 1'h1;
    frame(120, 2);
    drain();
    rdr(8'h04);
    chk(rd[9:8], 2'h0, "sequence");
    rdr(8'h08);
    chk(rd != 0, 32'h1, "errors");
    ign = 1'h0;
    frame(10, 0);
    drain();
    chk(q.size(), 32'h0, "leftover");
    summarize();
  end

  // Watchdog against a hang
  initial
  begin
    #2000000;
    error_cnt++;
    summarize();
  end
endmodule : tb_top
